// ### hw/axis_gear_and_limit_unit.sv
/*
  one axis of gear conversion, stroke check and in-position flag.
  assumes software drives the strobe port on clk, one strobe per cycle,
  and that the peripheral keeps backlash within the servo limit.
*/
// Summary of operation
// RULE1 - scale travel to pulses by gear ratio
// RULE2 - keep sub-pulse remainder, carry whole pulses out
// RULE3 - clear remainder on home, change, switch, pitch
// RULE4 - millimetre travel counted in 0.1 micrometre steps
// RULE5 - signed upper bound, reset to maximum
// RULE6 - signed lower bound, reset to zero
// RULE7 - in-position flag when distance within window
// RULE8 - degree axes may multiply speed by ten
// RULE9 - peripheral keeps backlash under servo limit
// RULE10 - two-bit unit code, default pulse
// RULE11 - out-of-stroke start refused with code 106
// RULE12 - window compared every cycle under position control
// RULE13 - exact integer divide, remainder kept per axis
// RULE14 - new settings take effect only at boundary; posctl takes effect on its ctrl write, without an apply
module axis_gear_and_limit_unit #(
  parameter int DIV_BITS = 64
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  output logic             cmd_inpos_flag,
  output logic             speed_x10,
  output logic             pulse_valid,
  output logic      [31:0] pulse_count
);

  // ----------------------------------------------------------------
  // shadow and active settings
  // ----------------------------------------------------------------
  axis_gear_pkg::axis_param_t shadow, next_shadow, active, next_active;
  logic        posctl, next_posctl;
  logic [31:0] backlash, next_backlash;
  logic [31:0] target, next_target;
  logic [31:0] current, next_current;
  logic [31:0] move, next_move;
  logic [7:0]  err, next_err;
  logic [5:0]  ev;
  logic        busy;

  assign ev = (wr && addr == axis_gear_pkg::ADDR_STATUS) ? wdata[5:0] : 6'h00;

  always_comb
  begin
    next_shadow   = shadow;
    next_active   = active;
    next_posctl   = posctl;
    next_backlash = backlash;
    next_target   = target;
    next_current  = current;
    if (wr)
    begin
      unique case (addr)
        axis_gear_pkg::ADDR_CTRL:
        begin
          next_shadow.unit    = wdata[axis_gear_pkg::CTRL_UNIT_LSB +: 2]; // see RULE10
          next_shadow.speed10 = wdata[axis_gear_pkg::CTRL_SPEED10];
          next_posctl         = wdata[axis_gear_pkg::CTRL_POSCTL];
        end
        axis_gear_pkg::ADDR_PULSES:   next_shadow.pulses_per_rev = wdata;
        axis_gear_pkg::ADDR_TRAVEL:   next_shadow.travel_per_rev = wdata; // see RULE4
        axis_gear_pkg::ADDR_UPPER:    next_shadow.upper = wdata; // see RULE5
        axis_gear_pkg::ADDR_LOWER:    next_shadow.lower = wdata; // see RULE6
        axis_gear_pkg::ADDR_WINDOW:   next_shadow.window = wdata;
        axis_gear_pkg::ADDR_BACKLASH: next_backlash = wdata; // see RULE9
        axis_gear_pkg::ADDR_TARGET:   next_target = wdata;
        axis_gear_pkg::ADDR_CURRENT:  next_current = wdata;
        default:
        begin
        end
      endcase
    end
    // settings only move across while no conversion is in flight,
    // and never beside a start, which would mix two ratios in one run
    if (ev[axis_gear_pkg::EV_APPLY] && !busy && !ev[axis_gear_pkg::EV_POS_START])
      next_active = shadow; // see RULE14
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      shadow.unit           <= axis_gear_pkg::UNIT_PULSE;
      shadow.speed10        <= 1'b0;
      shadow.pulses_per_rev <= axis_gear_pkg::RST_PULSES;
      shadow.travel_per_rev <= axis_gear_pkg::RST_TRAVEL;
      shadow.upper          <= axis_gear_pkg::RST_UPPER;
      shadow.lower          <= axis_gear_pkg::RST_LOWER;
      shadow.window         <= axis_gear_pkg::RST_WINDOW;
      active.unit           <= axis_gear_pkg::UNIT_PULSE;
      active.speed10        <= 1'b0;
      active.pulses_per_rev <= axis_gear_pkg::RST_PULSES;
      active.travel_per_rev <= axis_gear_pkg::RST_TRAVEL;
      active.upper          <= axis_gear_pkg::RST_UPPER;
      active.lower          <= axis_gear_pkg::RST_LOWER;
      active.window         <= axis_gear_pkg::RST_WINDOW;
      posctl                <= 1'b0;
      backlash              <= axis_gear_pkg::RST_BACKLASH;
      target                <= 32'h00000000;
      current               <= 32'h00000000;
    end
    else
    begin
      shadow   <= next_shadow;
      active   <= next_active;
      posctl   <= next_posctl;
      backlash <= next_backlash;
      target   <= next_target;
      current  <= next_current;
    end
  end

  // ----------------------------------------------------------------
  // conversion: (move * pulses + remainder) / travel, restoring divide
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_DIV  = 3'b010,
    S_DONE = 3'b100
  } conv_state_t;

  conv_state_t           state, next_state;
  logic [DIV_BITS-1:0]   dividend, next_dividend;
  logic [DIV_BITS-1:0]   quot, next_quot;
  logic [DIV_BITS:0]     part, next_part;
  logic [6:0]            step, next_step;
  logic                  neg, next_neg;
  logic [31:0]           rem, next_rem;
  logic                  stroke_ok;
  logic                  next_pulse_valid;
  logic [31:0]           next_pulse_count;
  logic [31:0]           mag;
  logic [DIV_BITS:0]     trial;
  logic                  clear_rem;

  assign busy      = (state != S_IDLE);
  // signed stroke window check on the fed position
  assign stroke_ok = ($signed(current) <= $signed(active.upper)) && ($signed(current) >= $signed(active.lower));
  assign mag       = move[31] ? 32'(-$signed(move)) : move;
  assign clear_rem = |ev[axis_gear_pkg::EV_PITCH_START:axis_gear_pkg::EV_HOME_DONE];
  assign trial     = {part[DIV_BITS-1:0], dividend[DIV_BITS-1]};

  always_comb
  begin
    next_state       = state;
    next_dividend    = dividend;
    next_quot        = quot;
    next_part        = part;
    next_step        = step;
    next_neg         = neg;
    next_rem         = rem;
    next_move        = move;
    next_err         = err;
    next_pulse_valid = 1'b0;
    next_pulse_count = pulse_count;
    if (wr && addr == axis_gear_pkg::ADDR_MOVE && !busy)
      next_move = wdata;
    unique case (state)
      S_IDLE:
      begin
        if (ev[axis_gear_pkg::EV_POS_START])
        begin
          if (!stroke_ok)
            next_err = axis_gear_pkg::ERR_STROKE; // see RULE11
          else
          begin
            next_err      = axis_gear_pkg::ERR_NONE;
            next_neg      = move[31];
            // remainder is kept as a magnitude and added to the travel whatever its direction
            next_dividend = DIV_BITS'(mag) * DIV_BITS'(active.pulses_per_rev) + DIV_BITS'(rem); // see RULE1
            next_quot     = '0;
            next_part     = '0;
            next_step     = 7'(DIV_BITS);
            next_state    = S_DIV;
          end
        end
      end
      S_DIV:
      begin
        // one quotient bit per cycle keeps the divider exact and small
        next_dividend = {dividend[DIV_BITS-2:0], 1'b0};
        if (trial >= {1'b0, DIV_BITS'(active.travel_per_rev)})
        begin
          next_part = trial - {1'b0, DIV_BITS'(active.travel_per_rev)}; // see RULE13
          next_quot = {quot[DIV_BITS-2:0], 1'b1};
        end
        else
        begin
          next_part = trial;
          next_quot = {quot[DIV_BITS-2:0], 1'b0};
        end
        next_step = step - 7'h01;
        if (step == 7'h01)
          next_state = S_DONE;
      end
      S_DONE:
      begin
        next_rem         = part[31:0]; // see RULE2
        next_pulse_count = neg ? 32'(-$signed(quot[31:0])) : quot[31:0];
        next_pulse_valid = 1'b1;
        next_state       = S_IDLE;
      end
      default:
        next_state = S_IDLE;
    endcase
    if (clear_rem && state == S_IDLE)
      next_rem = 32'h00000000; // see RULE3
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      state       <= S_IDLE;
      dividend    <= '0;
      quot        <= '0;
      part        <= '0;
      step        <= 7'h00;
      neg         <= 1'b0;
      rem         <= 32'h00000000;
      move        <= 32'h00000000;
      err         <= axis_gear_pkg::ERR_NONE;
      pulse_valid <= 1'b0;
      pulse_count <= 32'h00000000;
    end
    else
    begin
      state       <= next_state;
      dividend    <= next_dividend;
      quot        <= next_quot;
      part        <= next_part;
      step        <= next_step;
      neg         <= next_neg;
      rem         <= next_rem;
      move        <= next_move;
      err         <= next_err;
      pulse_valid <= next_pulse_valid;
      pulse_count <= next_pulse_count;
    end
  end

  // ----------------------------------------------------------------
  // in-position flag, speed option and read port
  // ----------------------------------------------------------------
  logic        next_inpos, next_x10;
  logic [31:0] diff, next_rdata;

  assign diff = target - current;

  always_comb
  begin
    // signed distance, window covers both sides of the target
    next_inpos = posctl && ($signed(diff) <= $signed(active.window)) && ($signed(diff) >= -$signed(active.window)); // see RULE7 see RULE12
    next_x10   = active.speed10 && (active.unit == axis_gear_pkg::UNIT_DEGREE); // see RULE8
    next_rdata = 32'h00000000;
    if (rd)
    begin
      unique case (addr)
        axis_gear_pkg::ADDR_CTRL:      next_rdata = {28'h0000000, posctl, shadow.speed10, shadow.unit};
        axis_gear_pkg::ADDR_PULSES:    next_rdata = shadow.pulses_per_rev;
        axis_gear_pkg::ADDR_TRAVEL:    next_rdata = shadow.travel_per_rev;
        axis_gear_pkg::ADDR_UPPER:     next_rdata = shadow.upper;
        axis_gear_pkg::ADDR_LOWER:     next_rdata = shadow.lower;
        axis_gear_pkg::ADDR_WINDOW:    next_rdata = shadow.window;
        axis_gear_pkg::ADDR_BACKLASH:  next_rdata = backlash;
        axis_gear_pkg::ADDR_TARGET:    next_rdata = target;
        axis_gear_pkg::ADDR_CURRENT:   next_rdata = current;
        axis_gear_pkg::ADDR_MOVE:      next_rdata = move;
        axis_gear_pkg::ADDR_STATUS:    next_rdata = {20'h00000, err, 1'b0, busy, speed_x10, cmd_inpos_flag};
        axis_gear_pkg::ADDR_REMAINDER: next_rdata = rem;
        axis_gear_pkg::ADDR_PULSEOUT:  next_rdata = pulse_count;
        default:                       next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cmd_inpos_flag <= 1'b0;
      speed_x10      <= 1'b0;
      rdata          <= 32'h00000000;
    end
    else
    begin
      cmd_inpos_flag <= next_inpos;
      speed_x10      <= next_x10;
      rdata          <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_start_ok;
    state == S_IDLE && ev[axis_gear_pkg::EV_POS_START] && stroke_ok;
  endsequence

  property p_conv_done;
    @(posedge clk) disable iff (!resetn)
    s_start_ok |-> ##66 pulse_valid;
  endproperty
  a_conv_done: assert property (p_conv_done) else $error("conversion pulse late"); // see RULE1

  property p_stroke_refuse;
    @(posedge clk) disable iff (!resetn)
    (state == S_IDLE && ev[axis_gear_pkg::EV_POS_START] && !stroke_ok) |=> (err == axis_gear_pkg::ERR_STROKE && state == S_IDLE);
  endproperty
  a_stroke_refuse: assert property (p_stroke_refuse) else $error("out of stroke start not refused"); // see RULE11

  property p_rem_below;
    @(posedge clk) disable iff (!resetn)
    pulse_valid |-> rem < active.travel_per_rev;
  endproperty
  a_rem_below: assert property (p_rem_below) else $error("remainder not below one pulse"); // see RULE2

  property p_rem_clear;
    @(posedge clk) disable iff (!resetn)
    (clear_rem && state == S_IDLE) |=> rem == 32'h00000000;
  endproperty
  a_rem_clear: assert property (p_rem_clear) else $error("remainder not cleared"); // see RULE3

  property p_inpos;
    @(posedge clk) disable iff (!resetn)
    (posctl && diff == target - current && $signed(diff) <= $signed(active.window)
      && $signed(diff) >= -$signed(active.window)) |=> cmd_inpos_flag;
  endproperty
  a_inpos: assert property (p_inpos) else $error("in-position flag missing"); // see RULE7

  property p_inpos_off;
    @(posedge clk) disable iff (!resetn)
    !posctl |=> !cmd_inpos_flag;
  endproperty
  a_inpos_off: assert property (p_inpos_off) else $error("flag outside position control"); // see RULE12

  property p_x10;
    @(posedge clk) disable iff (!resetn)
    speed_x10 |-> $past(active.unit) == axis_gear_pkg::UNIT_DEGREE;
  endproperty
  a_x10: assert property (p_x10) else $error("speed option on non-degree axis"); // see RULE8

  property p_hold_active;
    @(posedge clk) disable iff (!resetn)
    busy |=> $stable(active);
  endproperty
  a_hold_active: assert property (p_hold_active) else $error("settings changed mid conversion"); // see RULE14

endmodule

// ### shared/axis_gear_pkg.sv
/*
  shared definitions for the axis gear and limit unit: register map,
  reset values, unit codes, error code and struct carriers.
  assumes a single 25 MHz clock and a plain strobe register port.
*/
package axis_gear_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_PULSES    = 4'h1;
  localparam logic [3:0] ADDR_TRAVEL    = 4'h2;
  localparam logic [3:0] ADDR_UPPER     = 4'h3;
  localparam logic [3:0] ADDR_LOWER     = 4'h4;
  localparam logic [3:0] ADDR_WINDOW    = 4'h5;
  localparam logic [3:0] ADDR_BACKLASH  = 4'h6;
  localparam logic [3:0] ADDR_TARGET    = 4'h7;
  localparam logic [3:0] ADDR_CURRENT   = 4'h8;
  localparam logic [3:0] ADDR_MOVE      = 4'h9;
  localparam logic [3:0] ADDR_STATUS    = 4'hA;
  localparam logic [3:0] ADDR_REMAINDER = 4'hB;
  localparam logic [3:0] ADDR_PULSEOUT  = 4'hC;

  // ----------------------------------------------------------------
  // ctrl fields
  // ----------------------------------------------------------------
  localparam int CTRL_UNIT_LSB  = 0;
  localparam int CTRL_SPEED10   = 2;
  localparam int CTRL_POSCTL    = 3;

  // ----------------------------------------------------------------
  // event strobe register bits (write one to trigger)
  // ----------------------------------------------------------------
  localparam int EV_HOME_DONE   = 0;
  localparam int EV_CURCHG_DONE = 1;
  localparam int EV_SPDSW_START = 2;
  localparam int EV_PITCH_START = 3;
  localparam int EV_POS_START   = 4;
  localparam int EV_APPLY       = 5;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  UNIT_MM       = 2'h0;
  localparam logic [1:0]  UNIT_INCH     = 2'h1;
  localparam logic [1:0]  UNIT_DEGREE   = 2'h2;
  localparam logic [1:0]  UNIT_PULSE    = 2'h3;
  localparam logic [31:0] RST_PULSES    = 32'h00004E20;
  localparam logic [31:0] RST_TRAVEL    = 32'h00004E20;
  localparam logic [31:0] RST_UPPER     = 32'h7FFFFFFF;
  localparam logic [31:0] RST_LOWER     = 32'h00000000;
  localparam logic [31:0] RST_WINDOW    = 32'h00000064;
  localparam logic [31:0] RST_BACKLASH  = 32'h00000000;
  localparam logic [7:0]  ERR_STROKE    = 8'h6A;
  localparam logic [7:0]  ERR_NONE      = 8'h00;
  localparam logic [31:0] SPEED_MULT    = 32'h0000000A;
  localparam int          CYCLE_PERIOD_NS = 40;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  unit;
    logic        speed10;
    logic [31:0] pulses_per_rev;
    logic [31:0] travel_per_rev;
    logic [31:0] upper;
    logic [31:0] lower;
    logic [31:0] window;
  } axis_param_t;

  typedef struct packed {
    logic        busy;
    logic        pulse_valid;
    logic [31:0] pulses;
  } conv_out_t;

endpackage

// ### verification/servo_amp_model.sv
/*
  behavioural servo amplifier: sums the signed command pulses it is handed.
  assumes pulse_count is settled in every cycle where pulse_valid is high.
*/
module servo_amp_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        pulse_valid,
  input  wire logic [31:0] pulse_count,
  output longint           position
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // position accumulator
  // ------------------------------------------------------------
  // the amplifier never stalls the controller, so no ready path
  always @(posedge clk)
  begin
    if (!resetn)
      position <= 0;
    else if (pulse_valid === 1'b1)
      position <= position + longint'($signed(pulse_count));
  end
endmodule

// ### verification/tb_top.sv
/*
  self-checking bench for the axis gear and limit unit.
  assumes the strobe register port and the servo amplifier model beside it.
*/
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        clk;
  logic        resetn;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        cmd_inpos_flag;
  logic        speed_x10;
  logic        pulse_valid;
  logic [31:0] pulse_count;
  longint      position;
  int          n_fail;
  int          samples_checked;
  longint      rem;
  longint      ap;
  longint      al;
  longint      expect_pos;
  logic [31:0] cur_tab [4] = '{32'h00000384, 32'h00000383, 32'h0000044C, 32'h0000044D};
  logic        inp_tab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [31:0] lo_tab  [3] = '{32'h000003E8, 32'hFFFFFFF6, 32'h00000384};
  logic [31:0] hi_tab  [3] = '{32'h7FFFFFFF, 32'hFFFFFFFB, 32'h00000384};
  logic [31:0] st_tab  [3] = '{32'h000006A0, 32'h000006A0, 32'h00000000};

  initial clk = 1'b0;
  always #20 clk = ~clk;

  axis_gear_and_limit_unit axis_gear_and_limit_unit_inst (
    .clk            (clk),
    .resetn         (resetn),
    .addr           (addr),
    .wdata          (wdata),
    .wr             (wr),
    .rd             (rd),
    .rdata          (rdata),
    .cmd_inpos_flag (cmd_inpos_flag),
    .speed_x10      (speed_x10),
    .pulse_valid    (pulse_valid),
    .pulse_count    (pulse_count)
  );

  servo_amp_model servo_amp_model_inst (
    .clk         (clk),
    .resetn      (resetn),
    .pulse_valid (pulse_valid),
    .pulse_count (pulse_count),
    .position    (position)
  );

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe: sample mid-cycle
  task automatic chk_reg(input logic [3:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(nm, e, rdata)
  endtask

  task automatic apply();
    wr_reg(axis_gear_pkg::ADDR_STATUS, 32'h00000001 << axis_gear_pkg::EV_APPLY);
  endtask

  // expected pulses from the active ratio and the carried remainder
  task automatic move(input logic [31:0] mv, input logic ok);
    int     i;
    longint num;
    longint q;
    i = 0;
    wr_reg(axis_gear_pkg::ADDR_MOVE, mv);
    wr_reg(axis_gear_pkg::ADDR_STATUS, 32'h00000001 << axis_gear_pkg::EV_POS_START);
    // a new travel written mid conversion must be dropped
    if (ok)
      wr_reg(axis_gear_pkg::ADDR_MOVE, ~mv);
    while (i < 100 && pulse_valid !== 1'b1)
    begin
      @(negedge clk);
      i++;
    end
    if (ok)
    begin
      if (i == 100)
      begin
        n_fail++;
        print_verdict();
      end
      num = (($signed(mv) < 0) ? -longint'($signed(mv)) : longint'($signed(mv))) * ap + rem;
      q = num / al;
      rem = num % al;
      q = ($signed(mv) < 0) ? -q : q;
      expect_pos += q;
      `CHK("pulse_count", 32'(q), pulse_count)
      chk_reg(axis_gear_pkg::ADDR_REMAINDER, 32'(rem), "remainder");
      chk_reg(axis_gear_pkg::ADDR_MOVE, mv, "move held");
    end
    else
      `CHK("pulse seen", 1'b0, i < 100)
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    int k;
    resetn = 1'b0;
    addr = 4'h0;
    wdata = 32'h00000000;
    wr = 1'b0;
    rd = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    rem = 0;
    ap = 20000;
    al = 20000;
    expect_pos = 0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    chk_reg(axis_gear_pkg::ADDR_CTRL, 32'h00000003, "ctrl");
    chk_reg(axis_gear_pkg::ADDR_PULSES, 32'h00004E20, "pulses");
    chk_reg(axis_gear_pkg::ADDR_TRAVEL, 32'h00004E20, "travel");
    chk_reg(axis_gear_pkg::ADDR_UPPER, 32'h7FFFFFFF, "upper");
    chk_reg(axis_gear_pkg::ADDR_LOWER, 32'h00000000, "lower");
    chk_reg(axis_gear_pkg::ADDR_WINDOW, 32'h00000064, "window");
    chk_reg(axis_gear_pkg::ADDR_STATUS, 32'h00000000, "status");
    chk_reg(4'hF, 32'h00000000, "unmapped");
    move(32'h000004D2, 1'b1);
    $display("test reset_and_unity done");
    // 20 mm per turn held in 0.1 um steps
    wr_reg(axis_gear_pkg::ADDR_PULSES, 32'h00040000);
    wr_reg(axis_gear_pkg::ADDR_TRAVEL, 32'h00030D40);
    wr_reg(axis_gear_pkg::ADDR_CTRL, 32'h00000000);
    move(32'hFFFFFF38, 1'b1);
    chk_reg(axis_gear_pkg::ADDR_PULSES, 32'h00040000, "pulses shadow");
    apply();
    ap = 262144;
    al = 200000;
    move(32'h0002E630, 1'b1);
    move(32'h0002E630, 1'b1);
    move(32'hFFFD19D0, 1'b1);
    $display("test gear_fraction done");
    for (k = 0; k < 4; k++)
    begin
      move(32'h0000012C, 1'b1);
      wr_reg(axis_gear_pkg::ADDR_STATUS, 32'h00000001 << k);
      rem = 0;
      chk_reg(axis_gear_pkg::ADDR_REMAINDER, 32'h00000000, "cleared");
    end
    // kept small so the amplifier never trips on compensation
    wr_reg(axis_gear_pkg::ADDR_BACKLASH, 32'h00000010);
    chk_reg(axis_gear_pkg::ADDR_BACKLASH, 32'h00000010, "backlash");
    $display("test clear_events done");
    wr_reg(axis_gear_pkg::ADDR_CTRL, 32'h00000008);
    apply();
    wr_reg(axis_gear_pkg::ADDR_TARGET, 32'h000003E8);
    for (k = 0; k < 4; k++)
    begin
      wr_reg(axis_gear_pkg::ADDR_CURRENT, cur_tab[k]);
      repeat (3) @(negedge clk);
      `CHK("inpos", inp_tab[k], cmd_inpos_flag)
    end
    wr_reg(axis_gear_pkg::ADDR_WINDOW, 32'h00000032);
    wr_reg(axis_gear_pkg::ADDR_CURRENT, 32'h00000384);
    repeat (3) @(negedge clk);
    `CHK("inpos old window", 1'b1, cmd_inpos_flag)
    apply();
    repeat (3) @(negedge clk);
    `CHK("inpos new window", 1'b0, cmd_inpos_flag)
    $display("test in_position done");
    wr_reg(axis_gear_pkg::ADDR_CTRL, 32'h00000006);
    repeat (3) @(negedge clk);
    `CHK("speed before apply", 1'b0, speed_x10)
    apply();
    repeat (3) @(negedge clk);
    `CHK("speed degree", 1'b1, speed_x10)
    wr_reg(axis_gear_pkg::ADDR_CTRL, 32'h00000004);
    apply();
    repeat (3) @(negedge clk);
    `CHK("speed mm", 1'b0, speed_x10)
    $display("test speed_option done");
    for (k = 0; k < 3; k++)
    begin
      wr_reg(axis_gear_pkg::ADDR_LOWER, lo_tab[k]);
      wr_reg(axis_gear_pkg::ADDR_UPPER, hi_tab[k]);
      apply();
      move(32'h00000064, st_tab[k] == 32'h00000000);
      chk_reg(axis_gear_pkg::ADDR_STATUS, st_tab[k], "status err");
    end
    repeat (2) @(negedge clk);
    `CHK("servo position", 32'(expect_pos), 32'(position))
    $display("test stroke_and_servo done");
    print_verdict();
  end

  initial
  begin
    #4000000;
    n_fail++;
    print_verdict();
  end
endmodule
